// ### design/cbu_branch_unit.sv
// Branch resolution for branches on a second-coprocessor condition.
// Assumes the core offers one instruction per issue_valid and flags its own
// control transfers on issue_is_cti; the coprocessor drives all 32 conditions.
`timescale 1ns/100ps

// Operation
// - Current zero form branches on condition 0, non-zero form on condition non-zero.
// - The 5-bit selector reaches the coprocessor unchanged; 32 conditions possible.
// - Target is next instruction address plus sign-extended offset shifted by two.
// - Non-likely branches execute the delay slot before the target fetch.
// - New-release mode: control transfer in a delay slot raises reserved instruction.
// - Coprocessor access disabled raises coprocessor unusable, no evaluation.
// - Legacy false forms branch when the coded condition reads 0.
// - Legacy true forms branch when the coded condition reads 1.
// - Legacy likely forms nullify the slot when not taken.
// - Legacy forms carry a 3-bit code; code 0 is the default.
// - New-release mode has only the current forms; old-release mode has only the legacy forms.
// - Likely forms predict taken and bypass the prediction tables.
// - Current forms decode from fixed opcode, sub-op, selector and offset fields.
module cbu_branch_unit
  import cbu_pkg::*;
#(
  parameter int AW = 32
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register port, write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Register port, read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Instruction issue from the core
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [AW-1:0] issue_pc,
  input wire logic issue_is_cti,
  // Coprocessor conditions
  input wire logic [31:0] cop_cond_vec,
  output logic [4:0] cop_cond_sel,
  // Resolution results
  output logic res_valid,
  output logic res_taken,
  output logic predict_taken,
  output logic predict_bypass,
  output logic redirect_valid,
  output logic [AW-1:0] redirect_target,
  output logic slot_nullify,
  output logic exc_cop_unusable,
  output logic exc_reserved,
  // Interrupt
  output logic irq
);

  cbu_state_t state_r;
  logic cur_zero, cur_nonzero, legacy, legacy_true, legacy_likely;
  logic [4:0] sel;
  logic [15:0] offset;
  logic [AW-1:0] target;
  logic [1:0] ctrl_r;
  logic [CBU_EVT_W-1:0] status_r, mask_r, evt_set, evt_clr;
  logic rel6, cop_en, any_branch, form_ok, cond_bit, taken_now;
  logic issue_branch, eval, cu_now, slot_now, slot_cti_now, ri_now;
  logic slot_taken_r, slot_likely_r;
  logic [AW-1:0] slot_target_r;
  logic res_valid_r, res_taken_r, pred_taken_r, pred_bypass_r;
  logic redirect_valid_r, nullify_r, exc_cu_r, exc_ri_r;
  logic [AW-1:0] redirect_target_r;
  logic [4:0] cop_cond_sel_r;
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic do_write, ar_take;
  logic [7:0] ctrl_lane, mask_lane;

  // Known register offsets, shared by read and write decode
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == CBU_ADDR_CTRL) || (a == CBU_ADDR_STATUS) || (a == CBU_ADDR_MASK) ||
                 (a == CBU_ADDR_TARGET) || (a == CBU_ADDR_STATE);
  endfunction

  // Byte-lane merge for the narrow writable registers
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [7:0] nw, input logic en);
    lane0 = en ? nw : old;
  endfunction

  cbu_decode u_decode (
    .instr(issue_instr),
    .cur_zero(cur_zero),
    .cur_nonzero(cur_nonzero),
    .legacy(legacy),
    .legacy_true(legacy_true),
    .legacy_likely(legacy_likely),
    .cond_sel(sel),
    .offset(offset)
  );

  cbu_target #(.AW(AW)) u_target (
    .pc(issue_pc),
    .offset(offset),
    .target(target)
  );

  // Configuration bits
  assign rel6 = ctrl_r[CBU_CTRL_REL6_BIT];
  assign cop_en = ctrl_r[CBU_CTRL_COPEN_BIT];
  assign any_branch = cur_zero || cur_nonzero || legacy;

  // Which forms exist depends on the configured release
  // release form gating
  assign form_ok = rel6 ? (cur_zero || cur_nonzero) : legacy;

  // Every selector value reaches the condition vector
  // full selector range
  assign cond_bit = cop_cond_vec[sel];

  // Branch sense per form
  // zero and non-zero sense
  assign taken_now = cur_zero ? !cond_bit :
                     cur_nonzero ? cond_bit :
                     legacy_true ? cond_bit : !cond_bit;

  // Issue qualifiers; a branch sitting in a slot never starts a new resolution
  assign issue_branch = issue_valid && (state_r == CBU_IDLE) && any_branch;
  assign eval = issue_branch && form_ok && cop_en;
  assign cu_now = issue_branch && form_ok && !cop_en;
  assign slot_now = issue_valid && (state_r == CBU_SLOT);
  // Old-release slots are left alone, only new-release mode traps
  // slot transfer trap
  assign slot_cti_now = slot_now && rel6 && (issue_is_cti || any_branch);
  assign ri_now = (issue_branch && !form_ok) || slot_cti_now;

  // Branch and delay-slot sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= CBU_IDLE;
    else
      case (state_r)
        CBU_IDLE: if (eval) state_r <= CBU_SLOT;
        CBU_SLOT: if (issue_valid) state_r <= CBU_IDLE;
        default: state_r <= CBU_IDLE;
      endcase
  end

  // Remember the pending outcome until the slot instruction shows up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slot_taken_r <= 1'b0;
      slot_likely_r <= 1'b0;
      slot_target_r <= '0;
    end
    else if (eval)
    begin
      slot_taken_r <= taken_now;
      slot_likely_r <= legacy && legacy_likely;
      slot_target_r <= target;
    end
  end

  // Resolution and prediction pulses, one cycle after issue
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_valid_r <= 1'b0;
      res_taken_r <= 1'b0;
      pred_taken_r <= 1'b0;
      pred_bypass_r <= 1'b0;
      cop_cond_sel_r <= 5'h00;
    end
    else
    begin
      res_valid_r <= eval;
      res_taken_r <= eval && taken_now;
      // Likely forms are static taken so the tables never see them
      // static likely prediction
      pred_taken_r <= eval && (legacy_likely ? legacy : 1'b0);
      pred_bypass_r <= eval && legacy && legacy_likely;
      if (eval)
        cop_cond_sel_r <= sel;
    end
  end

  // Slot completion: redirect only after the slot instruction has issued
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      redirect_valid_r <= 1'b0;
      redirect_target_r <= '0;
      nullify_r <= 1'b0;
    end
    else
    begin
      redirect_valid_r <= slot_now && slot_taken_r && !slot_cti_now;
      if (slot_now && slot_taken_r && !slot_cti_now)
        redirect_target_r <= slot_target_r;
      nullify_r <= slot_now && slot_likely_r && !slot_taken_r && !slot_cti_now;
    end
  end

  // Exception pulses; a missing form wins over a disabled coprocessor
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      exc_cu_r <= 1'b0;
      exc_ri_r <= 1'b0;
    end
    else
    begin
      exc_cu_r <= cu_now;
      exc_ri_r <= ri_now;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  assign evt_set = {eval && taken_now, slot_now && slot_likely_r && !slot_taken_r && !slot_cti_now,
                    ri_now, cu_now};
  assign evt_clr = (ar_take && (araddr == CBU_ADDR_STATUS)) ? {CBU_EVT_W{1'b1}} : {CBU_EVT_W{1'b0}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_r <= '0;
    else
      status_r <= (status_r & ~evt_clr) | evt_set;
  end

  // Write address and data may arrive in either order
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready = !w_hold_r && !bvalid_r;
  assign do_write = aw_hold_r && w_hold_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      else if (do_write)
        aw_hold_r <= 1'b0;
      if (wvalid && wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      else if (do_write)
        w_hold_r <= 1'b0;
    end
  end

  // Byte 0 merged first; each register keeps only its own low bits
  assign ctrl_lane = lane0({6'h00, ctrl_r}, wdata_r[7:0], wstrb_r[0]);
  assign mask_lane = lane0({4'h0, mask_r}, wdata_r[7:0], wstrb_r[0]);

  // Writable registers; status is read-clear only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= CBU_CTRL_RESET;
      mask_r <= CBU_MASK_RESET;
    end
    else if (do_write)
    begin
      if (awaddr_r == CBU_ADDR_CTRL)
        ctrl_r <= ctrl_lane[1:0];
      else if (awaddr_r == CBU_ADDR_MASK)
        mask_r <= mask_lane[3:0];
    end
  end

  // Write response, held until accepted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= CBU_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= addr_known(awaddr_r) ? CBU_RESP_OKAY : CBU_RESP_SLVERR;
    end
    else if (bready)
      bvalid_r <= 1'b0;
  end

  // Read channel: one outstanding read, answered the cycle after the address
  assign arready = !rvalid_r;
  assign ar_take = arvalid && arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= CBU_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= addr_known(araddr) ? CBU_RESP_OKAY : CBU_RESP_SLVERR;
      if (araddr == CBU_ADDR_CTRL)
        rdata_r <= {30'h0000_0000, ctrl_r};
      else if (araddr == CBU_ADDR_STATUS)
        rdata_r <= {28'h000_0000, status_r};
      else if (araddr == CBU_ADDR_MASK)
        rdata_r <= {28'h000_0000, mask_r};
      else if (araddr == CBU_ADDR_TARGET)
        rdata_r <= 32'(slot_target_r);
      else if (araddr == CBU_ADDR_STATE)
        rdata_r <= {28'h000_0000, slot_likely_r, slot_taken_r, state_r};
      else
        rdata_r <= 32'h0000_0000;
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  // Output drive
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign cop_cond_sel = cop_cond_sel_r;
  assign res_valid = res_valid_r;
  assign res_taken = res_taken_r;
  assign predict_taken = pred_taken_r;
  assign predict_bypass = pred_bypass_r;
  assign redirect_valid = redirect_valid_r;
  assign redirect_target = redirect_target_r;
  assign slot_nullify = nullify_r;
  assign exc_cop_unusable = exc_cu_r;
  assign exc_reserved = exc_ri_r;
  // Level interrupt straight off the sticky bits
  assign irq = |(status_r & mask_r);

  // Checks on the resolution path
  default clocking cb_main @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cur_zero;
    eval && cur_zero |=> res_valid && (res_taken == !$past(cond_bit));
  endproperty
  a_cur_zero: assert property (p_cur_zero) else $error("zero form sense wrong");

  property p_sel_pass;
    eval |=> cop_cond_sel == $past(sel);
  endproperty
  a_sel_pass: assert property (p_sel_pass) else $error("selector not passed");

  property p_target;
    eval |=> slot_target_r == $past(issue_pc) + 32'h4 +
             {{14{$past(issue_instr[15])}}, $past(issue_instr[15:0]), 2'b00};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_slot_first;
    redirect_valid |-> $past(slot_now) && !res_valid;
  endproperty
  a_slot_first: assert property (p_slot_first) else $error("redirect before slot");

  property p_slot_cti;
    slot_now && rel6 && issue_is_cti |=> exc_reserved && !redirect_valid && !slot_nullify;
  endproperty
  a_slot_cti: assert property (p_slot_cti) else $error("slot transfer not trapped");

  property p_cop_off;
    issue_branch && form_ok && !cop_en |=> exc_cop_unusable && !res_valid ##1 state_r == CBU_IDLE;
  endproperty
  a_cop_off: assert property (p_cop_off) else $error("unusable not raised");

  property p_leg_false;
    eval && legacy && !legacy_true |=> res_taken == !$past(cond_bit);
  endproperty
  a_leg_false: assert property (p_leg_false) else $error("legacy false sense wrong");

  property p_leg_true;
    eval && legacy && legacy_true |=> res_taken == $past(cond_bit);
  endproperty
  a_leg_true: assert property (p_leg_true) else $error("legacy true sense wrong");

  property p_nullify;
    slot_now && slot_likely_r && !slot_taken_r && !slot_cti_now |=> slot_nullify && !redirect_valid;
  endproperty
  a_nullify: assert property (p_nullify) else $error("likely slot not nullified");

  property p_rel6_legacy;
    issue_branch && rel6 && legacy |=> exc_reserved && !res_valid;
  endproperty
  a_rel6_legacy: assert property (p_rel6_legacy) else $error("legacy form not refused");

  property p_likely_pred;
    eval && legacy && legacy_likely |=> predict_taken && predict_bypass;
  endproperty
  a_likely_pred: assert property (p_likely_pred) else $error("likely not predicted taken");

endmodule // cbu_branch_unit

// ### design/cbu_pkg.sv
// Shared constants and types for the coprocessor condition branch unit.
// Assumes a 32-bit instruction word and an AXI4-Lite register port with 32-bit data.
package cbu_pkg;

  // Instruction encoding
  localparam logic [5:0] CBU_OP_COP = 6'h12;
  localparam logic [4:0] CBU_SUB_ZERO = 5'h09;
  localparam logic [4:0] CBU_SUB_NONZERO = 5'h0D;
  localparam logic [4:0] CBU_SUB_LEGACY = 5'h08;
  localparam int CBU_OP_MSB = 31;
  localparam int CBU_OP_LSB = 26;
  localparam int CBU_SUB_MSB = 25;
  localparam int CBU_SUB_LSB = 21;
  localparam int CBU_SEL_MSB = 20;
  localparam int CBU_SEL_LSB = 16;
  localparam int CBU_CC_MSB = 20;
  localparam int CBU_CC_LSB = 18;
  localparam int CBU_LIKELY_BIT = 17;
  localparam int CBU_TRUE_BIT = 16;
  localparam int CBU_OFF_MSB = 15;

  // Target arithmetic
  localparam logic [31:0] CBU_PC_STEP = 32'h0000_0004;
  localparam int CBU_OFF_SHIFT = 2;

  // Register byte offsets
  localparam logic [11:0] CBU_ADDR_CTRL = 12'h000;
  localparam logic [11:0] CBU_ADDR_STATUS = 12'h004;
  localparam logic [11:0] CBU_ADDR_MASK = 12'h008;
  localparam logic [11:0] CBU_ADDR_TARGET = 12'h00C;
  localparam logic [11:0] CBU_ADDR_STATE = 12'h010;

  // Control fields and reset value
  localparam int CBU_CTRL_REL6_BIT = 0;
  localparam int CBU_CTRL_COPEN_BIT = 1;
  localparam logic [1:0] CBU_CTRL_RESET = 2'h1;

  // Status and mask layout
  localparam int CBU_EVT_W = 4;
  localparam int CBU_EVT_CU = 0;
  localparam int CBU_EVT_RI = 1;
  localparam int CBU_EVT_NULL = 2;
  localparam int CBU_EVT_TAKEN = 3;
  localparam logic [3:0] CBU_MASK_RESET = 4'h0;

  // Bus responses
  localparam logic [1:0] CBU_RESP_OKAY = 2'h0;
  localparam logic [1:0] CBU_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CBU_IDLE = 2'b01,
    CBU_SLOT = 2'b10
  } cbu_state_t;

endpackage

// ### design/cbu_decode.sv
// Instruction field decoder for the coprocessor condition branches.
// Assumes the instruction word is stable for the cycle it is offered.
`timescale 1ns/100ps
module cbu_decode
  import cbu_pkg::*;
(
  // Instruction in
  input wire logic [31:0] instr,
  // Decoded forms
  output logic cur_zero,
  output logic cur_nonzero,
  output logic legacy,
  output logic legacy_true,
  output logic legacy_likely,
  // Fields
  output logic [4:0] cond_sel,
  output logic [15:0] offset
);

  logic cop_major;

  // Major opcode and sub-op compare
  // fixed field decode
  assign cop_major = (instr[CBU_OP_MSB:CBU_OP_LSB] == CBU_OP_COP);
  assign cur_zero = cop_major && (instr[CBU_SUB_MSB:CBU_SUB_LSB] == CBU_SUB_ZERO);
  assign cur_nonzero = cop_major && (instr[CBU_SUB_MSB:CBU_SUB_LSB] == CBU_SUB_NONZERO);
  assign legacy = cop_major && (instr[CBU_SUB_MSB:CBU_SUB_LSB] == CBU_SUB_LEGACY);
  assign legacy_true = instr[CBU_TRUE_BIT];
  assign legacy_likely = instr[CBU_LIKELY_BIT];

  // Legacy forms use a 3-bit code, zero-extended into the common selector
  // three-bit code select
  assign cond_sel = legacy ? {2'h0, instr[CBU_CC_MSB:CBU_CC_LSB]} : instr[CBU_SEL_MSB:CBU_SEL_LSB];
  assign offset = instr[CBU_OFF_MSB:0];

endmodule // cbu_decode

// ### design/cbu_target.sv
// PC-relative branch target adder.
// Assumes the PC given is the address of the branch itself.
`timescale 1ns/100ps
module cbu_target
  import cbu_pkg::*;
#(
  parameter int AW = 32
)
(
  // Operands
  input wire logic [AW-1:0] pc,
  input wire logic [15:0] offset,
  // Result
  output logic [AW-1:0] target
);

  logic [AW-1:0] disp;

  // Shift by two, sign-extend, add to the following instruction address
  // target formation
  assign disp = {{(AW-18){offset[15]}}, offset, {CBU_OFF_SHIFT{1'b0}}};
  assign target = pc + CBU_PC_STEP[AW-1:0] + disp;

endmodule // cbu_target

// ### tb/cbu_cop_model.sv
// Behavioural model of the coprocessor condition flags at the far side.
// Assumes the bench loads new flags between branches; core clock, sync reset.
`timescale 1ns/100ps
module cbu_cop_model
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Flag load from the bench
  input wire logic load,
  input wire logic [31:0] load_val,
  // Condition vector to the core
  output logic [31:0] cond_vec
);
  logic [31:0] flags_r;

  // Flag register; every selector value reaches a live flag
  // all 32 flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_r <= 32'h0000_0000;
    else if (load)
      flags_r <= load_val;
  end

  // Registered, so the vector is steady through the issue cycle
  assign cond_vec = flags_r;
endmodule // cbu_cop_model

// ### tb/cbu_branch_unit_tb_top.sv
// Self-checking bench for the coprocessor condition branch unit.
// Assumes the flag model drives the conditions; one clock, sync reset.
`timescale 1ns/100ps
module cbu_branch_unit_tb_top
  import cbu_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata, cond_vec, redirect_target;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, irq, res_valid, res_taken, slot_nullify;
  logic predict_taken, predict_bypass, redirect_valid, exc_cop_unusable, exc_reserved;
  logic issue_valid = 1'b0, issue_is_cti = 1'b0, load = 1'b0, r6 = 1'b1;
  logic [31:0] issue_instr = 32'h0000_0000, issue_pc = 32'h0000_0000, load_val = 32'h0000_0000;
  logic [4:0] cop_cond_sel;
  int n_fail = 0, cmp_count = 0, seed = 86077;

  // Core clock, 8 ns period
  always #4 aclk = ~aclk;

  // Unit under test
  cbu_branch_unit dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .issue_valid(issue_valid), .issue_instr(issue_instr), .issue_pc(issue_pc),
    .issue_is_cti(issue_is_cti), .cop_cond_vec(cond_vec), .cop_cond_sel(cop_cond_sel),
    .res_valid(res_valid), .res_taken(res_taken), .predict_taken(predict_taken),
    .predict_bypass(predict_bypass), .redirect_valid(redirect_valid),
    .redirect_target(redirect_target), .slot_nullify(slot_nullify),
    .exc_cop_unusable(exc_cop_unusable), .exc_reserved(exc_reserved), .irq(irq)
  );

  // Far-side condition flags
  cbu_cop_model cop (
    .aclk(aclk), .aresetn(aresetn), .load(load), .load_val(load_val), .cond_vec(cond_vec)
  );

  // Expected target: next instruction plus offset scaled by four
  function automatic logic [31:0] tgt(input logic [31:0] pc, input logic [15:0] off);
    return pc + CBU_PC_STEP + {{14{off[15]}}, off, 2'b00};
  endfunction

  // Four-state compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // Verdict, the single end of the run
  task automatic close_out();
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Register write; both channels offered together, bready held until bvalid
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    bready <= 1'b0;
    chk(bvalid, 1'b1, "write answer missing");
    chk(bresp, CBU_RESP_OKAY, "write response");
  endtask

  // Register read with masked compare of data and response
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] re, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    rready <= 1'b0;
    chk(rvalid, 1'b1, "read answer missing");
    chk(rdata & m, e, "read data");
    chk(rresp, re, "read response");
  endtask

  // Load the far-side flags
  task automatic setc(input logic [31:0] v);
    @(posedge aclk);
    load <= 1'b1;
    load_val <= v;
    @(posedge aclk);
    load <= 1'b0;
  endtask

  // One issue cycle; returns just after the edge that answers it
  task automatic issue(input logic [31:0] ins, input logic [31:0] pc, input logic control_transfer_op);
    @(posedge aclk);
    issue_valid <= 1'b1;
    issue_instr <= ins;
    issue_pc <= pc;
    issue_is_cti <= control_transfer_op;
    @(posedge aclk);
    issue_valid <= 1'b0;
    issue_is_cti <= 1'b0;
    #1;
  endtask

  // Trapped branch: no evaluation, only the exception pulses
  task automatic exc(input logic [31:0] ins, input logic cu, input logic ri);
    issue(ins, 32'h0000_1000, 1'b0);
    chk(exc_cop_unusable, cu, "unusable trap");
    chk(exc_reserved, ri, "reserved trap");
    chk(res_valid, 1'b0, "trapped branch resolved");
  endtask

  // Branch then its delay slot, checked against the expected outcome
  task automatic br(input logic [31:0] ins, input logic [31:0] pc, input logic tk, input logic lk, input logic sc);
    issue(ins, pc, 1'b0);
    chk(res_valid, 1'b1, "branch not resolved");
    chk(res_taken, tk, "taken flag");
    chk({predict_taken, predict_bypass}, {lk, lk}, "prediction");
    issue(32'h0000_0000, pc + CBU_PC_STEP, sc);
    chk(exc_reserved, sc & r6, "slot trap");
    chk(redirect_valid, tk & !(sc & r6), "redirect");
    if (tk & !(sc & r6)) chk(redirect_target, tgt(pc, ins[15:0]), "target");
    chk(slot_nullify, lk & !tk, "nullify");
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] v, pc;
    logic [15:0] off;
    logic [4:0] sel;
    logic [2:0] cc;
    logic [1:0] f;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(CBU_ADDR_CTRL, 32'h0000_0001, CBU_RESP_OKAY, 32'hFFFF_FFFF);
    rdc(CBU_ADDR_STATUS, 32'h0000_0000, CBU_RESP_OKAY, 32'hFFFF_FFFF);
    rdc(12'h020, 32'h0000_0000, CBU_RESP_SLVERR, 32'hFFFF_FFFF);
    axi_wr(CBU_ADDR_MASK, 32'h0000_000F);
    exc({CBU_OP_COP, CBU_SUB_ZERO, 5'h03, 16'h0010}, 1'b1, 1'b0);
    chk(irq, 1'b1, "irq on trap");
    rdc(CBU_ADDR_STATUS, 32'h0000_0001, CBU_RESP_OKAY, 32'h0000_000F);
    chk(irq, 1'b0, "irq after clear");
    axi_wr(CBU_ADDR_CTRL, 32'h0000_0003);
    exc({CBU_OP_COP, CBU_SUB_LEGACY, 3'h0, 2'h1, 16'h0004}, 1'b0, 1'b1);
    // Current forms; selector and offset extremes first
    for (int i = 0; i < 16; i++)
    begin
      sel = (i < 2) ? {5{i[0]}} : 5'($random(seed));
      v = $random(seed);
      off = (i < 2) ? {i[0], {15{!i[0]}}} : 16'($random(seed));
      pc = $random(seed) & 32'hFFFF_FFFC;
      setc(v);
      br({CBU_OP_COP, i[0] ? CBU_SUB_ZERO : CBU_SUB_NONZERO, sel, off}, pc, v[sel] ^ i[0], 1'b0, i == 5);
      chk(cop_cond_sel, sel, "selector");
    end
    // Last branch was a zero form: target and outcome must read back
    rdc(CBU_ADDR_TARGET, tgt(pc, off), CBU_RESP_OKAY, 32'hFFFF_FFFF);
    rdc(CBU_ADDR_STATE, {28'h000_0000, 1'b0, !v[sel], 2'b01}, CBU_RESP_OKAY, 32'hFFFF_FFFF);
    axi_wr(CBU_ADDR_MASK, 32'h0000_0000);
    chk(irq, 1'b0, "irq masked");
    axi_wr(CBU_ADDR_MASK, 32'h0000_0002);
    chk(irq, 1'b1, "irq unmasked");
    rdc(CBU_ADDR_STATUS, 32'h0000_0002, CBU_RESP_OKAY, 32'h0000_0007);
    axi_wr(CBU_ADDR_CTRL, 32'h0000_0002);
    r6 = 1'b0;
    exc({CBU_OP_COP, CBU_SUB_NONZERO, 5'h01, 16'h0008}, 1'b0, 1'b1);
    // Legacy forms in turn; code 0 with fixed flags first
    for (int i = 0; i < 16; i++)
    begin
      f = 2'(i);
      cc = (i < 4) ? 3'h0 : 3'($random(seed));
      v = $random(seed);
      if (i < 4) v[0] = f[1];
      off = 16'($random(seed));
      pc = $random(seed) & 32'hFFFF_FFFC;
      setc(v);
      br({CBU_OP_COP, CBU_SUB_LEGACY, cc, f, off}, pc, v[cc] ~^ f[0], f[1], i == 9);
    end
    close_out;
  end

  // Hang guard, far above the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    close_out;
  end
endmodule // cbu_branch_unit_tb_top
